// File: core/tcc_pkg.sv
package tcc_pkg;
  localparam logic [11:0] TCC_CTRL1_OFS = 12'h000;
  localparam logic [11:0] TCC_CTRL2_OFS = 12'h004;
  localparam logic [11:0] TCC_STAT_OFS  = 12'h008;
  localparam logic [11:0] TCC_CAPA_OFS  = 12'h00C;
  localparam logic [11:0] TCC_CMPA_OFS  = 12'h010;
  localparam logic [11:0] TCC_CMPB_OFS  = 12'h014;
  localparam logic [11:0] TCC_CNT_OFS   = 12'h018;
  localparam logic [11:0] TCC_ACNT_OFS  = 12'h01C;
  localparam logic [11:0] TCC_CAPB_OFS  = 12'h020;
  localparam logic [7:0]  TCC_CTRL_RST  = 8'h00;
  localparam logic [15:0] TCC_CNT_RST   = 16'hFFFC;
  localparam logic [15:0] TCC_PWM_LOAD  = 16'hFFFC;
  localparam logic [15:0] TCC_CMP_RST   = 16'hFFFF;
  // control one fields
  localparam int TCC_C1_CAPIE = 7;
  localparam int TCC_C1_CMPIE = 6;
  localparam int TCC_C1_OVFIE = 5;
  localparam int TCC_C1_FRCB  = 4;
  localparam int TCC_C1_FRCA  = 3;
  localparam int TCC_C1_LVLB  = 2;
  localparam int TCC_C1_EDGA  = 1;
  localparam int TCC_C1_LVLA  = 0;
  // control two fields
  localparam int TCC_C2_PENA  = 7;
  localparam int TCC_C2_PENB  = 6;
  localparam int TCC_C2_OPM   = 5;
  localparam int TCC_C2_PWM   = 4;
  localparam int TCC_C2_CKH   = 3;
  localparam int TCC_C2_CKL   = 2;
  localparam int TCC_C2_EDGB  = 1;
  localparam int TCC_C2_EXT_CLOCK_EDGE = 0;
  // status fields
  localparam int TCC_S_CAPA   = 7;
  localparam int TCC_S_CMPA   = 6;
  localparam int TCC_S_OVF    = 5;
  localparam int TCC_S_CAPB   = 4;
  localparam int TCC_S_CMPB   = 3;
  localparam int TCC_S_DIS    = 2;
  localparam logic [1:0] TCC_CK_DIV4 = 2'h0;
  localparam logic [1:0] TCC_CK_DIV2 = 2'h1;
  localparam logic [1:0] TCC_CK_DIV8 = 2'h2;
  localparam logic [1:0] TCC_CK_EXT  = 2'h3;
  localparam logic       TCC_HAS_EXT = 1'b1;
endpackage : tcc_pkg

// File: core/tcc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// three-stage synchroniser; change seen once stages two and three agree
module tcc_sync (
  input  wire logic clk,   // clock
  input  wire logic rst_n, // sync reset
  input  wire logic d,     // async input
  output var  logic q,     // stable level
  output var  logic rise,  // one-cycle rising pulse
  output var  logic fall   // one-cycle falling pulse
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk) begin
    s1_q <= d;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // q follows the pin during reset so release brings no false edge
  always_ff @(posedge clk) begin
    if (!rst_n || s2_q == s3_q) begin
      q <= s3_q;
    end
  end

  always_comb begin
    rise = (s2_q == s3_q) && s3_q && !q;
    fall = (s2_q == s3_q) && !s3_q && q;
  end
endmodule : tcc_sync
`default_nettype wire

// File: core/tcc_prescale.sv
`timescale 1ns/1ns
`default_nettype none
// counter tick selector: divided clock or external pin edge
module tcc_prescale (
  input  wire logic       clk,     // clock
  input  wire logic       rst_n,   // sync reset
  input  wire logic       freeze,  // clear prescaler, stop ticks
  input  wire logic [1:0] sel,     // clock select
  input  wire logic       ext_r,   // external rise pulse
  input  wire logic       ext_f,   // external fall pulse
  input  wire logic       ext_edg, // external edge select
  output var  logic       tick     // one-cycle count enable
);
  logic [2:0] div_q;

  always_ff @(posedge clk) begin
    if (!rst_n || freeze) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  always_comb begin
    tick = 1'b0;
    if (!freeze) begin
      case (sel)
        tcc_pkg::TCC_CK_DIV4: tick = (div_q[1:0] == 2'h3);
        tcc_pkg::TCC_CK_DIV2: tick = div_q[0];
        tcc_pkg::TCC_CK_DIV8: tick = (div_q == 3'h7);
        default: begin
          tick = tcc_pkg::TCC_HAS_EXT &&
                 (ext_edg ? ext_r : ext_f);
        end
      endcase
    end
  end
endmodule : tcc_prescale
`default_nettype wire

// File: core/tcc_top.sv
`timescale 1ns/1ns
`default_nettype none
// 16-bit capture/compare timer with APB register access
module tcc_top (
  input  wire logic        MCLK,       // 125 MHz clock
  input  wire logic        RST_N,      // sync reset, active low
  input  wire logic        PSEL,       // apb select
  input  wire logic        PENABLE,    // apb access phase
  input  wire logic        PWRITE,     // apb direction
  input  wire logic [11:0] PADDR,      // apb byte address
  input  wire logic [31:0] PWDATA,     // apb write data
  output var  logic [31:0] PRDATA,     // apb read data
  output var  logic        PREADY,     // apb ready
  output var  logic        PSLVERR,    // apb error
  input  wire logic        CAPTURE_IN_A,        // capture pin a
  input  wire logic        CAPTURE_IN_B,        // capture pin b
  input  wire logic        EXT_COUNT_CLOCK_PIN, // external count clock
  output var  logic        COMPARE_OUT_A,       // compare pin a level
  output var  logic        COMPARE_OUT_A_OE,    // pin a owned by timer
  output var  logic        COMPARE_OUT_B,       // compare pin b level
  output var  logic        COMPARE_OUT_B_OE,    // pin b owned by timer
  output var  logic        TIMER_IRQ            // timer interrupt
);
  logic [7:0]  ctrl1_q;
  logic [7:0]  ctrl2_q;
  logic        dis_q;
  logic [15:0] cnt_q;
  logic [15:0] cmpa_q;
  logic [15:0] cmpb_q;
  logic [15:0] cmpa_act_q;
  logic [15:0] cmpb_act_q;
  logic [15:0] capa_q;
  logic [15:0] capb_q;
  logic        flg_capa_q;
  logic        flg_cmpa_q;
  logic        flg_ovf_q;
  logic        flg_capb_q;
  logic        flg_cmpb_q;
  logic        lvl_a_q;
  logic        lvl_b_q;
  logic        pulse_q;
  logic        stat_rd_q;
  logic        cap_a_r;
  logic        cap_a_f;
  logic        cap_b_r;
  logic        cap_b_f;
  logic        ext_r;
  logic        ext_f;
  logic        tick;
  logic        wr;
  logic        rd;
  logic        acc;
  logic        hit;
  logic        pwm_m;
  logic        opm_m;
  logic        ev_capa;
  logic        ev_capb;
  logic        match_a;
  logic        match_b;
  logic        pwm_end;
  logic        pwm_pend_q;
  logic        clr_capa;
  logic        clr_cmpa;
  logic        clr_ovf;
  logic        clr_capb;
  logic        clr_cmpb;
  logic        irq_d;
  logic [31:0] rdata_d;

  tcc_sync u_sync_a (
    .clk  (MCLK),
    .rst_n(RST_N),
    .d    (CAPTURE_IN_A),
    .q    (),
    .rise (cap_a_r),
    .fall (cap_a_f)
  );

  tcc_sync u_sync_b (
    .clk  (MCLK),
    .rst_n(RST_N),
    .d    (CAPTURE_IN_B),
    .q    (),
    .rise (cap_b_r),
    .fall (cap_b_f)
  );

  tcc_sync u_sync_x (
    .clk  (MCLK),
    .rst_n(RST_N),
    .d    (EXT_COUNT_CLOCK_PIN),
    .q    (),
    .rise (ext_r),
    .fall (ext_f)
  );

  tcc_prescale u_presc (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .freeze (dis_q),
    .sel    (ctrl2_q[tcc_pkg::TCC_C2_CKH:tcc_pkg::TCC_C2_CKL]),
    .ext_r  (ext_r),
    .ext_f  (ext_f),
    .ext_edg(ctrl2_q[tcc_pkg::TCC_C2_EXT_CLOCK_EDGE]),
    .tick   (tick)
  );

  // apb access: single-cycle answer in the access phase
  always_comb begin
    acc = PSEL && PENABLE;
    wr  = acc && PWRITE;
    rd  = acc && !PWRITE;
  end

  always_comb begin
    hit     = 1'b1;
    rdata_d = 32'h0000_0000;
    if (PADDR == tcc_pkg::TCC_CTRL1_OFS) begin
      rdata_d[7:0] = ctrl1_q;
    end else if (PADDR == tcc_pkg::TCC_CTRL2_OFS) begin
      rdata_d[7:0] = ctrl2_q;
    end else if (PADDR == tcc_pkg::TCC_STAT_OFS) begin
      rdata_d[7:0] = {flg_capa_q, flg_cmpa_q, flg_ovf_q, flg_capb_q,
                      flg_cmpb_q, dis_q, 2'h0};
    end else if (PADDR == tcc_pkg::TCC_CAPA_OFS) begin
      rdata_d[15:0] = capa_q;
    end else if (PADDR == tcc_pkg::TCC_CMPA_OFS) begin
      rdata_d[15:0] = cmpa_q;
    end else if (PADDR == tcc_pkg::TCC_CMPB_OFS) begin
      rdata_d[15:0] = cmpb_q;
    end else if (PADDR == tcc_pkg::TCC_CNT_OFS) begin
      rdata_d[15:0] = cnt_q;
    end else if (PADDR == tcc_pkg::TCC_ACNT_OFS) begin
      rdata_d[15:0] = cnt_q;
    end else if (PADDR == tcc_pkg::TCC_CAPB_OFS) begin
      rdata_d[15:0] = capb_q;
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rdata_d : 32'h0000_0000;
    end
  end

  // requests take effect at the edge where PREADY is seen high
  logic done;
  always_comb begin
    done = acc && PREADY;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl1_q <= tcc_pkg::TCC_CTRL_RST;
      ctrl2_q <= tcc_pkg::TCC_CTRL_RST;
      dis_q   <= 1'b0;
    end else if (done && wr) begin
      if (PADDR == tcc_pkg::TCC_CTRL1_OFS) begin
        ctrl1_q <= PWDATA[7:0];
      end else if (PADDR == tcc_pkg::TCC_CTRL2_OFS) begin
        ctrl2_q <= PWDATA[7:0];
      end else if (PADDR == tcc_pkg::TCC_STAT_OFS) begin
        dis_q <= PWDATA[tcc_pkg::TCC_S_DIS];
      end
    end
  end

  // compare buffers; PWM mode defers the active copy to period end
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cmpa_q     <= tcc_pkg::TCC_CMP_RST;
      cmpb_q     <= tcc_pkg::TCC_CMP_RST;
      cmpa_act_q <= tcc_pkg::TCC_CMP_RST;
      cmpb_act_q <= tcc_pkg::TCC_CMP_RST;
    end else begin
      if (done && wr && PADDR == tcc_pkg::TCC_CMPA_OFS) begin
        cmpa_q <= PWDATA[15:0];
      end
      if (done && wr && PADDR == tcc_pkg::TCC_CMPB_OFS) begin
        cmpb_q <= PWDATA[15:0];
      end
      if (!pwm_m || pwm_end) begin
        cmpa_act_q <= cmpa_q;
        cmpb_act_q <= cmpb_q;
      end
    end
  end

  always_comb begin
    pwm_m   = ctrl2_q[tcc_pkg::TCC_C2_PWM];
    opm_m   = ctrl2_q[tcc_pkg::TCC_C2_OPM] && !pwm_m;
    ev_capa = !pwm_m && (ctrl1_q[tcc_pkg::TCC_C1_EDGA] ?
              cap_a_r : cap_a_f);
    ev_capb = ctrl2_q[tcc_pkg::TCC_C2_EDGB] ? cap_b_r : cap_b_f;
    match_a = tick && (cnt_q == cmpa_act_q);
    match_b = tick && (cnt_q == cmpb_act_q);
    pwm_end = pwm_pend_q;
  end

  // period end registered one cycle after the b match in PWM mode
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pwm_pend_q <= 1'b0;
    end else begin
      pwm_pend_q <= pwm_m && match_b;
    end
  end

  // tick counter; reloaded on count writes, at the PWM b match and on capture a in one-pulse mode
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cnt_q <= tcc_pkg::TCC_CNT_RST;
    end else if (done && wr && (PADDR == tcc_pkg::TCC_CNT_OFS ||
                                PADDR == tcc_pkg::TCC_ACNT_OFS)) begin
      cnt_q <= tcc_pkg::TCC_CNT_RST;
    end else if (pwm_m && match_b) begin
      cnt_q <= tcc_pkg::TCC_PWM_LOAD;
    end else if (opm_m && ev_capa) begin
      cnt_q <= tcc_pkg::TCC_CNT_RST;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      capa_q <= 16'h0000;
      capb_q <= 16'h0000;
    end else begin
      if (ev_capa) begin
        capa_q <= cnt_q;
      end
      if (ev_capb) begin
        capb_q <= cnt_q;
      end
    end
  end

  // flags clear by status read then data access; a new event wins
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      stat_rd_q <= 1'b0;
    end else if (done) begin
      stat_rd_q <= rd && PADDR == tcc_pkg::TCC_STAT_OFS;
    end
  end

  always_comb begin
    clr_capa = done && stat_rd_q && PADDR == tcc_pkg::TCC_CAPA_OFS;
    clr_cmpa = done && stat_rd_q && PADDR == tcc_pkg::TCC_CMPA_OFS;
    clr_ovf  = done && stat_rd_q && PADDR == tcc_pkg::TCC_CNT_OFS;
    clr_capb = done && stat_rd_q && PADDR == tcc_pkg::TCC_CAPB_OFS;
    clr_cmpb = done && stat_rd_q && PADDR == tcc_pkg::TCC_CMPB_OFS;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      flg_capa_q <= 1'b0;
      flg_cmpa_q <= 1'b0;
      flg_ovf_q  <= 1'b0;
      flg_capb_q <= 1'b0;
      flg_cmpb_q <= 1'b0;
    end else begin
      flg_capa_q <= ev_capa || (pwm_m && match_b) ||
                    (flg_capa_q && !clr_capa);
      flg_cmpa_q <= (!pwm_m && match_a) || (flg_cmpa_q && !clr_cmpa);
      flg_ovf_q  <= (tick && cnt_q == 16'hFFFF && !(pwm_m && match_b)) ||
                    (flg_ovf_q && !clr_ovf);
      flg_capb_q <= ev_capb || (flg_capb_q && !clr_capb);
      flg_cmpb_q <= (!pwm_m && match_b) || (flg_cmpb_q && !clr_cmpb);
    end
  end

  // compare output levels
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      lvl_a_q <= 1'b0;
      lvl_b_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      if (pwm_m) begin
        if (match_a) begin
          lvl_a_q <= ctrl1_q[tcc_pkg::TCC_C1_LVLA];
        end else if (match_b) begin
          lvl_a_q <= ctrl1_q[tcc_pkg::TCC_C1_LVLB];
        end
      end else if (opm_m) begin
        if (ev_capa) begin
          lvl_a_q <= ctrl1_q[tcc_pkg::TCC_C1_LVLB];
          pulse_q <= 1'b1;
        end else if (pulse_q && match_a) begin
          lvl_a_q <= ctrl1_q[tcc_pkg::TCC_C1_LVLA];
          pulse_q <= 1'b0;
        end
      end else if (match_a || ctrl1_q[tcc_pkg::TCC_C1_FRCA]) begin
        lvl_a_q <= ctrl1_q[tcc_pkg::TCC_C1_LVLA];
      end
      if (!pwm_m && !opm_m &&
          (match_b || ctrl1_q[tcc_pkg::TCC_C1_FRCB])) begin
        lvl_b_q <= ctrl1_q[tcc_pkg::TCC_C1_LVLB];
      end
    end
  end

  // pin enables route only; compare logic runs regardless
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      COMPARE_OUT_A    <= 1'b0;
      COMPARE_OUT_A_OE <= 1'b0;
      COMPARE_OUT_B    <= 1'b0;
      COMPARE_OUT_B_OE <= 1'b0;
    end else begin
      COMPARE_OUT_A    <= lvl_a_q;
      COMPARE_OUT_A_OE <= ctrl2_q[tcc_pkg::TCC_C2_PENA] && !dis_q;
      COMPARE_OUT_B    <= lvl_b_q;
      COMPARE_OUT_B_OE <= ctrl2_q[tcc_pkg::TCC_C2_PENB] && !dis_q;
    end
  end

  always_comb begin
    irq_d = (ctrl1_q[tcc_pkg::TCC_C1_CAPIE] &&
             (flg_capa_q || flg_capb_q)) ||
            (ctrl1_q[tcc_pkg::TCC_C1_CMPIE] &&
             (flg_cmpa_q || flg_cmpb_q)) ||
            (ctrl1_q[tcc_pkg::TCC_C1_OVFIE] && flg_ovf_q);
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      TIMER_IRQ <= 1'b0;
    end else begin
      TIMER_IRQ <= irq_d;
    end
  end
endmodule : tcc_top
`default_nettype wire

// File: verif/tcc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tcc_checker (
  input wire logic        MCLK,                // clock
  input wire logic        RST_N,               // sync reset
  input wire logic        PSEL,                // apb select
  input wire logic        PENABLE,             // apb access
  input wire logic        PWRITE,              // apb direction
  input wire logic [11:0] PADDR,               // apb address
  input wire logic [31:0] PWDATA,              // apb write data
  input wire logic [31:0] PRDATA,              // apb read data
  input wire logic        PREADY,              // apb ready
  input wire logic        PSLVERR,             // apb error
  input wire logic        CAPTURE_IN_A,        // capture pin a
  input wire logic        CAPTURE_IN_B,        // capture pin b
  input wire logic        EXT_COUNT_CLOCK_PIN, // external clock
  input wire logic        COMPARE_OUT_A,       // pin a level
  input wire logic        COMPARE_OUT_A_OE,    // pin a enable
  input wire logic        COMPARE_OUT_B,       // pin b level
  input wire logic        COMPARE_OUT_B_OE,    // pin b enable
  input wire logic        TIMER_IRQ            // interrupt
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic       wr;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  // shadow copies of the two control registers
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
    end else if (wr && PADDR == 12'h000) begin
      c1_q <= PWDATA[7:0];
    end else if (wr && PADDR == 12'h004) begin
      c2_q <= PWDATA[7:0];
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (PREADY && PADDR > 12'h020 |-> PSLVERR)
    else $error("unmapped access without error");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside ready");
  a_ctrl_readback: assert property (
    PREADY && !PWRITE && PADDR == 12'h000 |-> PRDATA == {24'h0, c1_q})
    else $error("control one readback wrong");
  a_oe_a_enable: assert property (COMPARE_OUT_A_OE |-> $past(c2_q[7]))
    else $error("pin a driven while disabled");
  a_oe_b_enable: assert property (COMPARE_OUT_B_OE |-> $past(c2_q[6]))
    else $error("pin b driven while disabled");
  a_irq_masked: assert property ($past(c1_q[7:5]) == 3'h0 |-> !TIMER_IRQ)
    else $error("interrupt with all sources masked");
  a_force_a_level: assert property (
    (c1_q[3] && !c2_q[5] && !c2_q[4] && COMPARE_OUT_A_OE && $stable(c1_q))[*3]
    |-> COMPARE_OUT_A == c1_q[0])
    else $error("forced level a not on pin");
  a_force_b_level: assert property (
    (c1_q[4] && COMPARE_OUT_B_OE && $stable(c1_q))[*3]
    |-> COMPARE_OUT_B == c1_q[2])
    else $error("forced level b not on pin");
  c_irq: cover property (TIMER_IRQ);
  c_err: cover property (PSLVERR);
  c_pin_a: cover property ($rose(COMPARE_OUT_A));
endmodule : tcc_checker
bind tcc_top tcc_checker tcc_checker_inst (.MCLK, .RST_N, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CAPTURE_IN_A,
  .CAPTURE_IN_B, .EXT_COUNT_CLOCK_PIN, .COMPARE_OUT_A, .COMPARE_OUT_A_OE,
  .COMPARE_OUT_B, .COMPARE_OUT_B_OE, .TIMER_IRQ);
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } tcc_row_s;
  logic        MCLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        CAPTURE_IN_A, CAPTURE_IN_B, EXT_COUNT_CLOCK_PIN, er;
  logic        COMPARE_OUT_A, COMPARE_OUT_A_OE, COMPARE_OUT_B;
  logic        COMPARE_OUT_B_OE, TIMER_IRQ;
  int          error_cnt, checks, cyc, hi;
  tcc_row_s    rows[4] = '{'{12'h000, 32'h8A, 32'h8A, 1'b0},
                           '{12'h004, 32'h2D, 32'h2D, 1'b0},
                           '{12'h024, 32'hFF, 32'h00, 1'b1},
                           '{12'h0FC, 32'hFF, 32'h00, 1'b1}};
  tcc_top tcc_top_inst (.MCLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CAPTURE_IN_A, .CAPTURE_IN_B,
    .EXT_COUNT_CLOCK_PIN, .COMPARE_OUT_A, .COMPARE_OUT_A_OE, .COMPARE_OUT_B,
    .COMPARE_OUT_B_OE, .TIMER_IRQ);
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  task finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  // one apb transfer; read data and error taken at the ready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", e, rd & m);
  endtask : rc
  // toggles the external clock pin slowly enough for the synchroniser
  task pulse_ext(input int n);
    repeat (n) begin
      EXT_COUNT_CLOCK_PIN <= 1'b1;
      repeat (6) @(posedge MCLK);
      EXT_COUNT_CLOCK_PIN <= 1'b0;
      repeat (6) @(posedge MCLK);
    end
  endtask : pulse_ext
  initial begin
    RST_N <= 1'b0;
    {PSEL, PENABLE, PWRITE, EXT_COUNT_CLOCK_PIN} <= 4'h0;
    PADDR <= 12'h0;
    PWDATA <= 32'h0;
    CAPTURE_IN_A <= 1'b1;
    CAPTURE_IN_B <= 1'b1;
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    rc(12'h008, 32'hFF, 32'h00);
    rc(12'h000, 32'hFF, 32'h00);
    rc(12'h004, 32'hFF, 32'h00);
    rc(12'h010, 32'hFFFF, 32'hFFFF);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk("werr", rows[i].e, er);
      apb(1'b0, rows[i].a, 32'h0);
      chk("rdata", rows[i].r, rd);
      chk("rerr", rows[i].e, er);
    end
    apb(1'b1, 12'h004, 32'h00);
    apb(1'b1, 12'h000, 32'h82);
    CAPTURE_IN_A <= 1'b0;
    repeat (12) @(posedge MCLK);
    rc(12'h008, 32'h90, 32'h00);
    CAPTURE_IN_A <= 1'b1;
    repeat (12) @(posedge MCLK);
    rc(12'h008, 32'h90, 32'h80);
    chk("irq", 1, TIMER_IRQ);
    apb(1'b1, 12'h000, 32'h02);
    repeat (3) @(posedge MCLK);
    chk("irq", 0, TIMER_IRQ);
    CAPTURE_IN_B <= 1'b0;
    repeat (12) @(posedge MCLK);
    rc(12'h008, 32'h90, 32'h90);
    apb(1'b1, 12'h000, 32'h20);
    repeat (3) @(posedge MCLK);
    chk("irq", 1, TIMER_IRQ);
    apb(1'b1, 12'h004, 32'hC0);
    apb(1'b1, 12'h000, 32'h1D);
    repeat (4) @(posedge MCLK);
    chk("pins", 4'hF, {COMPARE_OUT_A_OE, COMPARE_OUT_A, COMPARE_OUT_B_OE,
        COMPARE_OUT_B});
    apb(1'b1, 12'h000, 32'h18);
    repeat (4) @(posedge MCLK);
    chk("pins", 4'hA, {COMPARE_OUT_A_OE, COMPARE_OUT_A, COMPARE_OUT_B_OE,
        COMPARE_OUT_B});
    apb(1'b1, 12'h004, 32'h00);
    repeat (4) @(posedge MCLK);
    chk("oe", 0, {COMPARE_OUT_A_OE, COMPARE_OUT_B_OE});
    apb(1'b1, 12'h010, 32'h10);
    apb(1'b1, 12'h004, 32'hC4);
    apb(1'b1, 12'h000, 32'h45);
    apb(1'b1, 12'h018, 32'h00);
    repeat (100) @(posedge MCLK);
    chk("match", 2'h3, {COMPARE_OUT_A, COMPARE_OUT_B});
    chk("irq", 1, TIMER_IRQ);
    rc(12'h008, 32'h48, 32'h48);
    // pwm: high 37 of 69 ticks per period, one tick every two cycles
    apb(1'b1, 12'h000, 32'h04);
    apb(1'b1, 12'h014, 32'h40);
    apb(1'b1, 12'h010, 32'h20);
    apb(1'b1, 12'h004, 32'h94);
    repeat (200) @(posedge MCLK);
    hi = 0;
    repeat (414) begin
      @(posedge MCLK);
      hi += int'(COMPARE_OUT_A);
    end
    chk("pwm", 222, hi);
    // external clock: three rising edges, then one falling edge
    apb(1'b1, 12'h000, 32'h08);
    apb(1'b1, 12'h004, 32'h0D);
    apb(1'b1, 12'h018, 32'h00);
    pulse_ext(3);
    rc(12'h018, 32'hFFFF, 32'hFFFF);
    apb(1'b1, 12'h004, 32'h0C);
    pulse_ext(1);
    rc(12'h018, 32'hFFFF, 32'h0000);
    // one pulse on a rising capture edge, length from compare a
    CAPTURE_IN_A <= 1'b0;
    apb(1'b1, 12'h000, 32'h06);
    apb(1'b1, 12'h004, 32'hA4);
    chk("opm", 0, COMPARE_OUT_A);
    CAPTURE_IN_A <= 1'b1;
    repeat (12) @(posedge MCLK);
    chk("opm", 1, COMPARE_OUT_A);
    repeat (88) @(posedge MCLK);
    chk("opm", 0, COMPARE_OUT_A);
    // status read then capture a access clears the capture a flag
    rc(12'h008, 32'h80, 32'h80);
    apb(1'b0, 12'h00C, 32'h0);
    rc(12'h008, 32'h80, 32'h00);
    // reset in mid-run returns pins, flags and registers to idle
    RST_N <= 1'b0;
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    chk("rst", 0, {COMPARE_OUT_A_OE, COMPARE_OUT_B,
        COMPARE_OUT_B_OE});
    rc(12'h008, 32'hFC, 32'h00);
    rc(12'h000, 32'hFF, 32'h00);
    rc(12'h010, 32'hFFFF, 32'hFFFF);
    finish_test();
  end
endmodule : tb
`default_nettype wire
